// ### rtl/quadrature_position_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "qpc_defines.svh"

module quadrature_position_counter #(
    parameter int unsigned DEB_LIM_2 = `DEB_TICKS(`DEB_T2_US),
    parameter int unsigned DEB_LIM_3 = `DEB_TICKS(`DEB_T3_US)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire qpc_pkg::axil_req_type axil_req,
    output var qpc_pkg::axil_rsp_type axil_rsp,
    input wire logic quad_chan_a_input,
    input wire logic quad_chan_b_input,
    input wire logic quad_index_input,
    input wire logic [12:0] dig_other_input,
    output logic count_output,
    output logic count_irq
);
    import qpc_pkg::*;

    localparam int unsigned DEB_LIM_0 = `DEB_TICKS(`DEB_T0_US);
    localparam int unsigned DEB_LIM_1 = `DEB_TICKS(`DEB_T1_US);

    // bus state
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [15:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;

    // software registers
    logic [15:0] deb_en_r;
    logic [31:0] deb_dur_r;
    logic const_set_r;
    logic [15:0] ctrl_r;
    logic [31:0] const_a1_r;
    logic [31:0] const_b1_r;
    logic [31:0] const_a2_r;
    logic [31:0] const_b2_r;
    logic [31:0] readback_r;
    logic int_en_r;
    logic [15:0] dig_state_r;

    // counting state
    run_state_type run_r;
    run_state_type run_nxt;
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic [8:0] facc_r;
    logic ctick_r;
    logic [4:0] dacc_r;
    logic dtick_r;
    logic qa_r;
    logic qb_r;
    logic qi_r;
    logic qa_p;
    logic qb_p;
    logic qi_p;
    logic qnew_r;
    logic [15:0] deb_out;

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
        return addr[15:2] == off[15:2];
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
        return (old & ~strb_mask(strb)) | (data & strb_mask(strb));
    endfunction

    function automatic logic phase_hit(input logic [2:0] code, input logic a, input logic b);
        case (code)
            `IDX_A0B1: return !a && b;
            `IDX_A1B0: return a && !b;
            `IDX_A1B1: return a && b;
            `IDX_A0B0: return !a && !b;
            default: return 1'b0;
        endcase
    endfunction

    // bus write decode
    wire wr_do = !awready_r && !wready_r && !bvalid_r;
    wire [31:0] wr_bits = w_data_r & strb_mask(w_strb_r);
    wire wr_deb_en = wr_do && hit(aw_addr_r, `OFF_DEB_EN);
    wire wr_deb_dur = wr_do && hit(aw_addr_r, `OFF_DEB_DUR);
    wire wr_cmd = wr_do && hit(aw_addr_r, `OFF_CMD);
    wire wr_ctrl = wr_do && hit(aw_addr_r, `OFF_CTRL);
    wire wr_ca1 = wr_do && hit(aw_addr_r, `OFF_CONST_A1);
    wire wr_cb1 = wr_do && hit(aw_addr_r, `OFF_CONST_B1);
    wire wr_ca2 = wr_do && hit(aw_addr_r, `OFF_CONST_A2);
    wire wr_cb2 = wr_do && hit(aw_addr_r, `OFF_CONST_B2);
    wire wr_int_en = wr_do && hit(aw_addr_r, `OFF_INT_EN);
    wire wr_int_stat = wr_do && hit(aw_addr_r, `OFF_INT_STAT);
    wire wr_ro = hit(aw_addr_r, `OFF_READBACK) || hit(aw_addr_r, `OFF_COUNT)
                 || hit(aw_addr_r, `OFF_DIG_STATE);
    wire wr_known = wr_deb_en || wr_deb_dur || wr_cmd || wr_ctrl || wr_ca1 || wr_cb1
                    || wr_ca2 || wr_cb2 || wr_int_en || wr_int_stat || (wr_do && wr_ro);

    // command strobes, never stored
    wire trig_pulse = wr_cmd && wr_bits[`CMD_TRIG];
    wire load_pulse = wr_cmd && wr_bits[`CMD_LOAD];
    wire stop_pulse = wr_cmd && wr_bits[`CMD_STOP];
    wire clr_pulse = wr_int_stat && wr_bits[0];

    // bus read decode
    wire [15:0] ra = axil_req.araddr;
    wire [31:0] rd_cmd = {7'h0, const_set_r, 24'h0};
    wire rd_known = hit(ra, `OFF_DEB_EN) || hit(ra, `OFF_DEB_DUR) || hit(ra, `OFF_CMD)
                    || hit(ra, `OFF_CTRL) || hit(ra, `OFF_CONST_A1) || hit(ra, `OFF_CONST_B1)
                    || hit(ra, `OFF_CONST_A2) || hit(ra, `OFF_CONST_B2)
                    || hit(ra, `OFF_READBACK) || hit(ra, `OFF_INT_EN)
                    || hit(ra, `OFF_INT_STAT) || hit(ra, `OFF_COUNT)
                    || hit(ra, `OFF_DIG_STATE);
    wire [31:0] rdata_sel =
        hit(ra, `OFF_DEB_EN) ? {16'h0, deb_en_r} :
        hit(ra, `OFF_DEB_DUR) ? deb_dur_r :
        hit(ra, `OFF_CMD) ? rd_cmd :
        hit(ra, `OFF_CTRL) ? {16'h0, ctrl_r} :
        hit(ra, `OFF_CONST_A1) ? const_a1_r :
        hit(ra, `OFF_CONST_B1) ? const_b1_r :
        hit(ra, `OFF_CONST_A2) ? const_a2_r :
        hit(ra, `OFF_CONST_B2) ? const_b2_r :
        hit(ra, `OFF_READBACK) ? readback_r :
        hit(ra, `OFF_INT_EN) ? {31'h0, int_en_r} :
        hit(ra, `OFF_INT_STAT) ? {31'h0, count_irq} :
        hit(ra, `OFF_COUNT) ? count_r :
        hit(ra, `OFF_DIG_STATE) ? {16'h0, dig_state_r} : 32'h0;

    assign axil_rsp.awready = awready_r;
    assign axil_rsp.wready = wready_r;
    assign axil_rsp.bvalid = bvalid_r;
    assign axil_rsp.bresp = bresp_r;
    assign axil_rsp.arready = arready_r;
    assign axil_rsp.rvalid = rvalid_r;
    assign axil_rsp.rdata = rdata_r;
    assign axil_rsp.rresp = rresp_r;

    // write channels: address and data held until the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            aw_addr_r <= 16'h0;
        end else if (awready_r && axil_req.awvalid) begin
            awready_r <= 1'b0;
            aw_addr_r <= axil_req.awaddr;
        end else if (bvalid_r && axil_req.bready) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b1;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
        end else if (wready_r && axil_req.wvalid) begin
            wready_r <= 1'b0;
            w_data_r <= axil_req.wdata;
            w_strb_r <= axil_req.wstrb;
        end else if (bvalid_r && axil_req.bready) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
        end else if (wr_do) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_r && axil_req.bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // read channel: one read under way, answered the cycle after it is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= `RESP_OKAY;
        end else if (arready_r && axil_req.arvalid) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rdata_sel;
            rresp_r <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_r && axil_req.rready) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // register file, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            deb_en_r <= 16'h0;
            deb_dur_r <= `REG_RST;
            const_a1_r <= `REG_RST;
            const_b1_r <= `REG_RST;
            const_a2_r <= `REG_RST;
            const_b2_r <= `REG_RST;
            int_en_r <= 1'b0;
        end else begin
            if (wr_deb_en) deb_en_r <= 16'(wmerge({16'h0, deb_en_r}, w_data_r, w_strb_r));
            if (wr_deb_dur) deb_dur_r <= wmerge(deb_dur_r, w_data_r, w_strb_r);
            if (wr_ca1) const_a1_r <= wmerge(const_a1_r, w_data_r, w_strb_r);
            if (wr_cb1) const_b1_r <= wmerge(const_b1_r, w_data_r, w_strb_r);
            if (wr_ca2) const_a2_r <= wmerge(const_a2_r, w_data_r, w_strb_r);
            if (wr_cb2) const_b2_r <= wmerge(const_b2_r, w_data_r, w_strb_r);
            if (wr_int_en && w_strb_r[0]) int_en_r <= w_data_r[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            const_set_r <= 1'b0;
        end else if (wr_cmd && w_strb_r[3]) begin
            const_set_r <= w_data_r[`CMD_SET];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= 16'(wmerge({16'h0, ctrl_r}, w_data_r, w_strb_r));
        end else if (stop_pulse) begin
            ctrl_r[`CTRL_MODE] <= `MODE_OFF;
        end
    end

    // constant set in use
    wire [31:0] const_a = const_set_r ? const_a2_r : const_a1_r;
    wire [31:0] const_b = const_set_r ? const_b2_r : const_b1_r;

    // debounce time base: 5/32 of 200 MHz is 31.25 MHz
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dacc_r <= 5'h0;
            dtick_r <= 1'b0;
        end else begin
            {dtick_r, dacc_r} <= {1'b0, dacc_r} + `DEB_ACC_STEP;
        end
    end

    input_debounce deb (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw({dig_other_input, quad_index_input, quad_chan_b_input, quad_chan_a_input}),
        .enable(deb_en_r),
        .dur_sel(deb_dur_r),
        .tick(dtick_r),
        .lim0(DEB_LIM_0[17:0]),
        .lim1(DEB_LIM_1[17:0]),
        .lim2(DEB_LIM_2[17:0]),
        .lim3(DEB_LIM_3[17:0]),
        .filtered(deb_out)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) dig_state_r <= 16'h0;
        else dig_state_r <= deb_out;
    end

    // counter operating frequency, fraction of 200 MHz over 512
    wire [2:0] freq_code = ctrl_r[`CTRL_FREQ];
    wire [9:0] freq_step = (freq_code == 3'h0) ? `FREQ_STEP_0 :
                           (freq_code == 3'h1) ? `FREQ_STEP_1 :
                           (freq_code == 3'h2) ? `FREQ_STEP_2 :
                           (freq_code == 3'h3) ? `FREQ_STEP_3 :
                           (freq_code == 3'h4) ? `FREQ_STEP_4 : 10'h000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            facc_r <= 9'h0;
            ctick_r <= 1'b0;
        end else begin
            {ctick_r, facc_r} <= {1'b0, facc_r} + freq_step;
        end
    end

    // input sampling at the counter rate
    wire b_use = ctrl_r[`CTRL_BEN] && deb_out[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {qa_r, qb_r, qi_r, qa_p, qb_p, qi_p} <= 6'h0;
            qnew_r <= 1'b0;
        end else begin
            qnew_r <= ctick_r;
            if (ctick_r) begin
                {qa_p, qb_p, qi_p} <= {qa_r, qb_r, qi_r};
                {qa_r, qb_r, qi_r} <= {deb_out[0], b_use, deb_out[2]};
            end
        end
    end

    // edge decode
    wire a_rise = qnew_r && qa_r && !qa_p;
    wire a_fall = qnew_r && !qa_r && qa_p;
    wire b_rise = qnew_r && qb_r && !qb_p;
    wire b_fall = qnew_r && !qb_r && qb_p;
    wire a_up = (a_rise && !qb_r) || (a_fall && qb_r);
    wire a_dn = (a_rise && qb_r) || (a_fall && !qb_r);
    wire b_up = (b_rise && qa_r) || (b_fall && !qa_r);
    wire b_dn = (b_rise && !qa_r) || (b_fall && qa_r);
    wire [1:0] rate = ctrl_r[`CTRL_RATE];

    wire step_up = (rate == `RATE_X1) ? (a_rise && !qb_r) :
                   (rate == `RATE_X2) ? a_up :
                   (rate == `RATE_X4) ? (a_up || b_up) : 1'b0;
    wire step_dn = (rate == `RATE_X1) ? (a_fall && !qb_r) :
                   (rate == `RATE_X2) ? a_dn :
                   (rate == `RATE_X4) ? (a_dn || b_dn) : 1'b0;

    // conditions
    wire mode_quad = ctrl_r[`CTRL_MODE] == `MODE_QUAD;
    wire running = (run_r == RUN_ACTIVE) && mode_quad;
    wire [1:0] out_sel = ctrl_r[`CTRL_OUT];
    wire idx_cond = mode_quad && qi_r && phase_hit(ctrl_r[`CTRL_IDX], qa_r, qb_r);
    wire eq_cond = running && (count_r == const_a);
    wire reload = running && (out_sel == `OUT_IDX_RELOAD) && idx_cond;
    wire hw_load = mode_quad && (ctrl_r[`CTRL_IDX] == `IDX_LOAD) && qnew_r
                   && qi_r && !qi_p;
    wire out_cond = ((out_sel == `OUT_EQ_A) && eq_cond) || (out_sel[1] && idx_cond);
    wire irq_event = out_cond || hw_load;

    // run control
    always_comb begin
        run_nxt = run_r;
        case (run_r)
            RUN_IDLE: begin
                if (trig_pulse && mode_quad) run_nxt = RUN_ACTIVE;
            end
            RUN_ACTIVE: begin
                if (!mode_quad) run_nxt = RUN_IDLE;
            end
            default: run_nxt = RUN_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) run_r <= RUN_IDLE;
        else run_r <= run_nxt;
    end

    // position count
    assign count_nxt = reload ? const_b :
                       (running && step_up) ? count_r + 32'h1 :
                       (running && step_dn) ? count_r - 32'h1 : count_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) count_r <= 32'h0;
        else count_r <= count_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) readback_r <= 32'h0;
        else if (load_pulse || hw_load) readback_r <= count_r;
    end

    // pending interrupt: a new event beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) count_irq <= 1'b0;
        else count_irq <= (count_irq && !clr_pulse) || (irq_event && int_en_r);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) count_output <= 1'b1;
        else count_output <= ctrl_r[`CTRL_POL] ? out_cond : !out_cond;
    end
endmodule

`default_nettype wire

// ### rtl/qpc_defines.svh
`ifndef QPC_DEFINES_SVH
`define QPC_DEFINES_SVH

`define OFF_DEB_EN 16'h7050
`define OFF_DEB_DUR 16'h7054
`define OFF_CMD 16'h7070
`define OFF_CTRL 16'h7074
`define OFF_CONST_A1 16'h7078
`define OFF_CONST_B1 16'h707c
`define OFF_CONST_A2 16'h7080
`define OFF_CONST_B2 16'h7084
`define OFF_READBACK 16'h7088
`define OFF_INT_EN 16'h708c
`define OFF_INT_STAT 16'h7090
`define OFF_COUNT 16'h7094
`define OFF_DIG_STATE 16'h7098

`define CMD_TRIG 0
`define CMD_LOAD 8
`define CMD_STOP 16
`define CMD_SET 24

`define CTRL_MODE 2:0
`define CTRL_POL 3
`define CTRL_RATE 5:4
`define CTRL_BEN 6
`define CTRL_IDX 9:7
`define CTRL_FREQ 12:10
`define CTRL_OUT 14:13
`define CTRL_RST 16'h0000
`define REG_RST 32'h0000_0000

`define MODE_OFF 3'h0
`define MODE_QUAD 3'h1
`define RATE_X1 2'h1
`define RATE_X2 2'h2
`define RATE_X4 2'h3
`define IDX_A0B1 3'h1
`define IDX_A1B0 3'h2
`define IDX_A1B1 3'h3
`define IDX_A0B0 3'h4
`define IDX_LOAD 3'h7
`define OUT_EQ_A 2'h1
`define OUT_IDX_RELOAD 2'h2

`define DEB_CLK_KHZ 31250
`define DEB_T0_US 4
`define DEB_T1_US 64
`define DEB_T2_US 1000
`define DEB_T3_US 8000
`define DEB_TICKS(us) ((us) * `DEB_CLK_KHZ / 1000)
`define DEB_ACC_STEP 6'h05
`define FREQ_STEP_0 10'h005
`define FREQ_STEP_1 10'h00a
`define FREQ_STEP_2 10'h014
`define FREQ_STEP_3 10'h028
`define FREQ_STEP_4 10'h0a0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### rtl/qpc_pkg.sv
package qpc_pkg;

typedef struct packed {
    logic [15:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [15:0] araddr;
    logic arvalid;
    logic rready;
} axil_req_type;

typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
} axil_rsp_type;

typedef enum logic [1:0] {
    RUN_IDLE = 2'b01,
    RUN_ACTIVE = 2'b10
} run_state_type;

endpackage

// ### rtl/input_debounce.sv
`timescale 1ns/10ps
`default_nettype none

module input_debounce (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] raw,
    input wire logic [15:0] enable,
    input wire logic [31:0] dur_sel,
    input wire logic tick,
    input wire logic [17:0] lim0,
    input wire logic [17:0] lim1,
    input wire logic [17:0] lim2,
    input wire logic [17:0] lim3,
    output logic [15:0] filtered
);
    logic [17:0] cnt_r [16];

    function automatic logic [17:0] limit(input logic [1:0] code, input logic [17:0] l0,
                                          input logic [17:0] l1, input logic [17:0] l2,
                                          input logic [17:0] l3);
        case (code)
            2'h0: return l0;
            2'h1: return l1;
            2'h2: return l2;
            default: return l3;
        endcase
    endfunction

    // bypassed channels follow the pin, filtered ones need a stable run
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 16; i++) begin
            if (!aresetn) begin
                filtered[i] <= 1'b0;
                cnt_r[i] <= 18'h0;
            end else if (!enable[i]) begin
                filtered[i] <= raw[i];
                cnt_r[i] <= 18'h0;
            end else if (raw[i] == filtered[i]) begin
                cnt_r[i] <= 18'h0;
            end else if (tick) begin
                if (cnt_r[i] + 18'h1 >= limit(dur_sel[2*i+:2], lim0, lim1, lim2, lim3)) begin
                    filtered[i] <= raw[i];
                    cnt_r[i] <= 18'h0;
                end else begin
                    cnt_r[i] <= cnt_r[i] + 18'h1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ### tb/qpc_checker.sv
`timescale 1ns/10ps
`default_nettype none

module qpc_checker #(
    parameter int unsigned DEB_LIM_2 = 20,
    parameter int unsigned DEB_LIM_3 = 40
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire qpc_pkg::axil_req_type axil_req,
    input wire qpc_pkg::axil_rsp_type axil_rsp,
    input wire logic quad_chan_a_input,
    input wire logic quad_chan_b_input,
    input wire logic quad_index_input,
    input wire logic [12:0] dig_other_input,
    input wire logic count_output,
    input wire logic count_irq
);
    import qpc_pkg::*;
    wire logic aw_hs = axil_req.awvalid && axil_rsp.awready;
    wire logic w_hs = axil_req.wvalid && axil_rsp.wready;
    wire logic ar_hs = axil_req.arvalid && axil_rsp.arready;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_state_a: assert property (
        $rose(aresetn) |-> axil_rsp.awready && axil_rsp.arready && !axil_rsp.bvalid
            && !axil_rsp.rvalid && !count_irq && count_output)
        else $error("bus or outputs not idle after reset");
    wr_answer_a: assert property (
        aw_hs && w_hs |=> !axil_rsp.bvalid ##1 axil_rsp.bvalid)
        else $error("write response not two cycles after handshake");
    rd_answer_a: assert property (ar_hs |=> axil_rsp.rvalid)
        else $error("read data not one cycle after address");
    b_hold_a: assert property (
        axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid && $stable(axil_rsp.bresp))
        else $error("write response dropped before bready");
    r_hold_a: assert property (
        axil_rsp.rvalid && !axil_req.rready |=> axil_rsp.rvalid && $stable(axil_rsp.rdata))
        else $error("read data dropped before rready");
    wr_block_a: assert property (
        axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready)
        else $error("write taken while response pending");
    rd_block_a: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
        else $error("read taken while data pending");
    irq_hold_a: assert property (
        count_irq && !aw_hs && !w_hs |=> count_irq || $rose(axil_rsp.bvalid))
        else $error("pending interrupt dropped without a write");
    cover property (aw_hs && w_hs);
    cover property (ar_hs);
    cover property ($rose(count_irq));
endmodule

bind quadrature_position_counter qpc_checker #(
    .DEB_LIM_2(DEB_LIM_2),
    .DEB_LIM_3(DEB_LIM_3)
) qpc_checker_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .axil_req(axil_req),
    .axil_rsp(axil_rsp),
    .quad_chan_a_input(quad_chan_a_input),
    .quad_chan_b_input(quad_chan_b_input),
    .quad_index_input(quad_index_input),
    .dig_other_input(dig_other_input),
    .count_output(count_output),
    .count_irq(count_irq)
);

`default_nettype wire

// ### tb/quad_encoder.sv
`timescale 1ns/10ps
`default_nettype none

module quad_encoder (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic step,
    input wire logic fwd,
    input wire logic idx_en,
    output logic quad_a,
    output logic quad_b,
    output logic quad_idx
);
    logic [1:0] phase_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= 2'h0;
        end else if (step) begin
            phase_r <= fwd ? phase_r + 2'h1 : phase_r - 2'h1;
        end
    end
    // phases 00,10,11,01 for a,b: a leads b when moving forward
    assign quad_a = phase_r[1] ^ phase_r[0];
    assign quad_b = phase_r[1];
    assign quad_idx = idx_en && (phase_r == 2'h0);
endmodule

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "qpc_defines.svh"

module tb;
    import qpc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    axil_req_type req = '0;
    axil_rsp_type rsp;
    logic step = 1'b0;
    logic fwd = 1'b1;
    logic idx_en = 1'b0;
    logic [12:0] dig = 13'h0000;
    logic qa, qb, qi, cout, irq;
    logic [31:0] rv, c0;
    logic [1:0] resp;
    int err_count = 0;
    int samples_checked = 0;

    always #2.5 aclk = ~aclk;

    quadrature_position_counter #(.DEB_LIM_2(20), .DEB_LIM_3(40)) quadrature_position_counter_i (
        .aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
        .quad_chan_a_input(qa), .quad_chan_b_input(qb), .quad_index_input(qi),
        .dig_other_input(dig), .count_output(cout), .count_irq(irq));
    quad_encoder quad_encoder_i (.aclk(aclk), .aresetn(aresetn), .step(step), .fwd(fwd),
        .idx_en(idx_en), .quad_a(qa), .quad_b(qb), .quad_idx(qi));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] ad, input logic [31:0] d, input logic [3:0] s = 4'hf);
        int n;
        @(posedge aclk);
        req.awaddr <= ad;
        req.wdata <= d;
        req.wstrb <= s;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
            if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        resp = rsp.bresp;
        req.bready <= 1'b0;
        if (n == 200) begin
            err_count++;
            print_verdict();
        end
    endtask

    task automatic rd(input logic [15:0] ad);
        int n;
        @(posedge aclk);
        req.araddr <= ad;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        rv = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        if (n == 200) begin
            err_count++;
            print_verdict();
        end
    endtask

    task automatic rdc(input logic [15:0] ad, input logic [31:0] e);
        rd(ad);
        chk($sformatf("reg %h", ad), e, rv);
    endtask

    task automatic mv(input logic f, input int q);
        repeat (q) begin
            @(posedge aclk);
            fwd <= f;
            step <= 1'b1;
            @(posedge aclk);
            step <= 1'b0;
            repeat (12) @(posedge aclk);
        end
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(`OFF_DEB_EN, 32'h0);
        rdc(`OFF_DEB_DUR, 32'h0);
        rdc(`OFF_CMD, 32'h0);
        rdc(`OFF_CTRL, 32'h0);
        wr(16'h7ffc, 32'h1);
        chk("bresp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
        rd(16'h7ffc);
        chk("rresp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
        wr(`OFF_DEB_EN, 32'hffff_ffff);
        rdc(`OFF_DEB_EN, 32'h0000_ffff);
        wr(`OFF_DEB_EN, 32'h0);
        wr(`OFF_DEB_DUR, 32'h1b1b_e4e4);
        rdc(`OFF_DEB_DUR, 32'h1b1b_e4e4);
        wr(`OFF_CTRL, 32'h0000_ab00, 4'h2);
        wr(`OFF_CTRL, 32'h0000_ff01, 4'h1);
        rdc(`OFF_CTRL, 32'h0000_ab01);
        wr(`OFF_CMD, 32'h0001_0000);
        rdc(`OFF_CTRL, 32'h0000_ab00);
        wr(`OFF_CMD, 32'h0100_0000);
        rdc(`OFF_CMD, 32'h0100_0000);
        wr(`OFF_CMD, 32'h0);
        dig <= 13'h1abc;
        repeat (4) @(posedge aclk);
        rdc(`OFF_DIG_STATE, {16'h0, 13'h1abc, 3'h0});
        wr(`OFF_DEB_EN, 32'h0000_0008);
        dig <= 13'h1abd;
        rdc(`OFF_DIG_STATE, {16'h0, 13'h1abc, 3'h0});
        repeat (768) @(posedge aclk);
        rdc(`OFF_DIG_STATE, {16'h0, 13'h1abd, 3'h0});
        wr(`OFF_DEB_EN, 32'h0);
        for (int r = 1; r < 4; r++) begin
            wr(`OFF_CMD, 32'h0001_0000);
            wr(`OFF_CTRL, 32'h0000_1041 | (32'(r) << 4));
            rd(`OFF_COUNT);
            c0 = rv;
            mv(1'b1, 4);
            rdc(`OFF_COUNT, c0);
            wr(`OFF_CMD, 32'h1);
            mv(1'b1, 4);
            rdc(`OFF_COUNT, c0 + (32'h1 << (r - 1)));
            mv(1'b0, 4);
            rdc(`OFF_COUNT, c0);
        end
        wr(`OFF_CMD, 32'h100);
        rdc(`OFF_READBACK, c0);
        wr(`OFF_CONST_B1, 32'h123);
        wr(`OFF_CONST_B2, 32'h456);
        wr(`OFF_INT_EN, 32'h1);
        wr(`OFF_CTRL, 32'h0000_5271);
        wr(`OFF_CMD, 32'h1);
        idx_en <= 1'b1;
        repeat (12) @(posedge aclk);
        rdc(`OFF_COUNT, 32'h123);
        chk("count_output", 32'h0, {31'h0, cout});
        chk("count_irq", 32'h1, {31'h0, irq});
        wr(`OFF_CMD, 32'h0100_0000);
        repeat (12) @(posedge aclk);
        rdc(`OFF_COUNT, 32'h456);
        wr(`OFF_INT_STAT, 32'h1);
        repeat (4) @(posedge aclk);
        chk("count_irq", 32'h1, {31'h0, irq});
        idx_en <= 1'b0;
        repeat (12) @(posedge aclk);
        wr(`OFF_INT_STAT, 32'h1);
        chk("count_irq", 32'h0, {31'h0, irq});
        chk("count_output", 32'h1, {31'h0, cout});
        wr(`OFF_CTRL, 32'h0000_13f1);
        mv(1'b1, 4);
        rdc(`OFF_COUNT, 32'h45a);
        idx_en <= 1'b1;
        repeat (12) @(posedge aclk);
        idx_en <= 1'b0;
        rdc(`OFF_READBACK, 32'h45a);
        chk("count_irq", 32'h1, {31'h0, irq});
        wr(`OFF_CTRL, 32'h0000_1031);
        mv(1'b1, 4);
        rdc(`OFF_COUNT, 32'h45a);
        wr(`OFF_CONST_A2, 32'h45b);
        wr(`OFF_CTRL, 32'h0000_3071);
        mv(1'b1, 1);
        chk("count_output", 32'h0, {31'h0, cout});
        print_verdict();
    end
endmodule

`default_nettype wire
